// ---- shared/pcei_pkg.sv ----
// constants and types for the pin control and external interrupt block
// Behaviour
// - Option bit picks falling-edge-only or falling-edge-plus-low-level interrupt input sensing.
// - Third port pin interrupts are always falling-edge, whatever the option bit says.
// - All eight third port pins request interrupts only while the interrupt is enabled.
// - A dedicated option bit enables or disables the watchdog system.
// - With its option bit set, low supply holds the processor in reset.
// - Option bit disables stop; executing stop then causes a reset instead.
// - Options are individual bits of an option register held in programmable memory.
// - Two operating modes: user firmware mode and bootloader programming mode.
// - Oscillator output is the inverted oscillator input, forced high in stop mode.
// - Internal operating clock is the source clock divided by two.
// - External low on reset pin restarts the whole controller; input has hysteresis.
// - Device pulls reset pin low on every internal reset source.
// - Interrupt input raises a request that the processor interrupt mask can block.
// - Ports of seven, eight, eight lines; direction programmable; inputs after reset.
// - Second port shared: serial lowest four, two PWM, compare, capture on top.
// - Five analog pins are digital inputs while converter off; converter resets off.
// - Converter on: selected channel pin reads 0, others read true levels.
// - Converter control bits select which shared analog pin is routed.
package pcei_pkg;
    localparam int PA_W = 7;
    localparam int PB_W = 8;
    localparam int PC_W = 8;
    localparam int PD_W = 5;
    localparam int OPT_W = 4;
    localparam int CNT_W = 6;
    // register offsets
    localparam logic [7:0] OFF_PA_DATA = 8'h00;
    localparam logic [7:0] OFF_PB_DATA = 8'h01;
    localparam logic [7:0] OFF_PC_DATA = 8'h02;
    localparam logic [7:0] OFF_PD_DATA = 8'h03;
    localparam logic [7:0] OFF_PA_DIR = 8'h04;
    localparam logic [7:0] OFF_PB_DIR = 8'h05;
    localparam logic [7:0] OFF_PC_DIR = 8'h06;
    localparam logic [7:0] OFF_AD_CTRL = 8'h1e;
    localparam logic [7:0] OFF_IRQ_CTRL = 8'h1f;
    localparam logic [7:0] OFF_OPTION = 8'h20;
    localparam logic [7:0] OFF_MODE = 8'h21;
    // option register bits
    localparam int OPT_IRQ_LEVEL = 0;
    localparam int OPT_WDOG_EN = 1;
    localparam int OPT_LVR_EN = 2;
    localparam int OPT_STOP_DIS = 3;
    // converter control fields
    localparam int AD_ON_BIT = 7;
    localparam int AD_CH_LSB = 0;
    localparam int AD_CH_W = 3;
    // interrupt control fields
    localparam int IRQ_EN_BIT = 1;
    localparam int IRQ_ACK_BIT = 2;
    localparam int IRQ_PEND_BIT = 3;
    localparam int IRQ_PIN_BIT = 0;
    // reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int RST_HOLD_NS = 1000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] RST_HOLD = CNT_W'(RST_HOLD_CYC);
    localparam int OP_DIV = 2;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcei_bus_t;

    typedef struct packed {
        logic [OPT_W-1:0] opt;
        logic opt_valid;
        logic boot_mode;
        logic [CNT_W-1:0] rst_cnt;
        logic [1:0] rst_s;
        logic [1:0] irq_s;
        logic irq_prev;
        logic [PC_W-1:0] pc_s0;
        logic [PC_W-1:0] pc_s1;
        logic [PC_W-1:0] pc_prev;
        logic [PA_W-1:0] pa_s0;
        logic [PA_W-1:0] pa_s1;
        logic [PB_W-1:0] pb_s0;
        logic [PB_W-1:0] pb_s1;
        logic [PD_W-1:0] pd_s0;
        logic [PD_W-1:0] pd_s1;
        logic [1:0] osc_s;
        logic osc_prev;
        logic div;
        logic [PA_W-1:0] pa_d;
        logic [PB_W-1:0] pb_d;
        logic [PC_W-1:0] pc_d;
        logic [PA_W-1:0] pa_dir;
        logic [PB_W-1:0] pb_dir;
        logic [PC_W-1:0] pc_dir;
        logic ad_on;
        logic [AD_CH_W-1:0] ad_chan;
        logic irq_en;
        logic pend;
        logic stop_mode;
        logic [7:0] rdata;
    } pcei_state_t;
endpackage

// ---- design/pcei_pin_ctrl.sv ----
// pin control, option bits, reset pin and external interrupt logic
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pcei_pin_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire pcei_pkg::pcei_bus_t bus,
    output logic [7:0] rdata,
    input wire logic [pcei_pkg::OPT_W-1:0] option_config_register,
    input wire logic boot_strap,
    output logic boot_mode,
    output logic watchdog_system_en,
    input wire logic watchdog_timeout,
    input wire logic low_supply_detect,
    input wire logic illegal_addr,
    input wire logic stop_exec,
    output logic stop_mode,
    output logic cpu_reset,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic oscillator_input_pin,
    output logic oscillator_output_pin,
    output logic op_clock_out,
    input wire logic irq_pin_in,
    input wire logic cpu_irq_mask,
    input wire logic cpu_irq_ack,
    output logic irq_req,
    input wire logic [pcei_pkg::PA_W-1:0] first_port_lines_in,
    output logic [pcei_pkg::PA_W-1:0] first_port_lines_out,
    output logic [pcei_pkg::PA_W-1:0] first_port_lines_oe,
    input wire logic [pcei_pkg::PB_W-1:0] second_port_in,
    output logic [pcei_pkg::PB_W-1:0] second_port_out,
    output logic [pcei_pkg::PB_W-1:0] second_port_oe,
    input wire logic second_port_serial_en,
    input wire logic [3:0] second_port_serial_lines_out,
    input wire logic [3:0] second_port_serial_lines_oe,
    output logic [3:0] second_port_serial_lines_in,
    input wire logic pwm_a_en,
    input wire logic second_port_pwm_out_a,
    input wire logic pwm_b_en,
    input wire logic second_port_pwm_out_b,
    input wire logic compare_en,
    input wire logic second_port_compare_out,
    input wire logic capture_en,
    output logic second_port_capture_in,
    input wire logic [pcei_pkg::PC_W-1:0] third_port_wakeup_lines_in,
    output logic [pcei_pkg::PC_W-1:0] third_port_wakeup_lines_out,
    output logic [pcei_pkg::PC_W-1:0] third_port_wakeup_lines_oe,
    input wire logic [pcei_pkg::PD_W-1:0] analog_shared_inputs,
    output logic ad_enable,
    output logic [pcei_pkg::AD_CH_W-1:0] ad_channel
);
    pcei_pkg::pcei_state_t st;
    pcei_pkg::pcei_state_t next_st;

    logic lvl_on;
    logic stop_dis;
    logic int_rst;
    logic irq_fall;
    logic [pcei_pkg::PC_W-1:0] pc_fall;
    logic irq_set;
    logic irq_clr;
    logic level_req;
    logic wake;
    logic osc_rise;
    logic [pcei_pkg::PD_W-1:0] pd_mask;
    logic [pcei_pkg::PA_W-1:0] pa_rd;
    logic [pcei_pkg::PB_W-1:0] pb_rd;
    logic [pcei_pkg::PC_W-1:0] pc_rd;
    logic [pcei_pkg::PD_W-1:0] pd_rd;
    logic [pcei_pkg::PB_W-1:0] pb_own;
    logic [pcei_pkg::PB_W-1:0] pb_per_out;
    logic [pcei_pkg::PB_W-1:0] pb_per_oe;

    // option bits are only trusted once captured after reset release
    assign lvl_on = st.opt_valid & st.opt[pcei_pkg::OPT_IRQ_LEVEL];
    assign stop_dis = st.opt_valid & st.opt[pcei_pkg::OPT_STOP_DIS];

    // every internal reset source reloads the pin pull-down counter
    assign int_rst = (st.opt[pcei_pkg::OPT_WDOG_EN] & watchdog_timeout)
        | (st.opt[pcei_pkg::OPT_LVR_EN] & low_supply_detect)
        | illegal_addr
        | (stop_exec & stop_dis);

    assign irq_fall = st.irq_prev & ~st.irq_s[1];
    assign pc_fall = st.pc_prev & ~st.pc_s1;
    assign irq_set = st.irq_en & (irq_fall | (|pc_fall));
    assign irq_clr = cpu_irq_ack
        | (bus.wr & (bus.addr == pcei_pkg::OFF_IRQ_CTRL) & bus.wdata[pcei_pkg::IRQ_ACK_BIT]);
    assign level_req = lvl_on & st.irq_en & ~st.irq_s[1];
    assign wake = st.pend | level_req;
    assign osc_rise = st.osc_s[1] & ~st.osc_prev;

    // selected converter channel reads as zero
    always_comb begin
        pd_mask = '0;
        if (st.ad_on && (st.ad_chan < 3'(pcei_pkg::PD_W))) begin
            pd_mask[st.ad_chan] = 1'b1;
        end
    end

    // peripheral ownership of the second port
    assign pb_own = {capture_en, compare_en, pwm_b_en, pwm_a_en, {4{second_port_serial_en}}};
    assign pb_per_out = {1'b0, second_port_compare_out, second_port_pwm_out_b,
        second_port_pwm_out_a, second_port_serial_lines_out};
    assign pb_per_oe = {1'b0, 1'b1, 1'b1, 1'b1, second_port_serial_lines_oe};

    assign pa_rd = (st.pa_dir & st.pa_d) | (~st.pa_dir & st.pa_s1);
    assign pb_rd = (st.pb_dir & st.pb_d & ~pb_own) | ((~st.pb_dir | pb_own) & st.pb_s1);
    assign pc_rd = (st.pc_dir & st.pc_d) | (~st.pc_dir & st.pc_s1);
    assign pd_rd = st.pd_s1 & ~pd_mask;

    always_comb begin
        next_st = st;
        // synchronisers: first stage feeds only the second
        next_st.rst_s = {st.rst_s[0], reset_pin_in};
        next_st.irq_s = {st.irq_s[0], irq_pin_in};
        next_st.irq_prev = st.irq_s[1];
        next_st.pc_s0 = third_port_wakeup_lines_in;
        next_st.pc_s1 = st.pc_s0;
        next_st.pc_prev = st.pc_s1;
        next_st.pa_s0 = first_port_lines_in;
        next_st.pa_s1 = st.pa_s0;
        next_st.pb_s0 = second_port_in;
        next_st.pb_s1 = st.pb_s0;
        next_st.pd_s0 = analog_shared_inputs;
        next_st.pd_s1 = st.pd_s0;
        next_st.osc_s = {st.osc_s[0], oscillator_input_pin};
        next_st.osc_prev = st.osc_s[1];
        if (osc_rise) begin
            next_st.div = ~st.div;
        end
        // options and mode strap caught on the first edge after release
        if (!st.opt_valid) begin
            next_st.opt = option_config_register;
            next_st.boot_mode = boot_strap;
            next_st.opt_valid = 1'b1;
        end
        // reset pin pull-down stretch
        if (int_rst) begin
            next_st.rst_cnt = pcei_pkg::RST_HOLD;
        end else if (st.rst_cnt != '0) begin
            next_st.rst_cnt = st.rst_cnt - 1'b1;
        end
        // stop entry and wake
        if (cpu_reset || wake) begin
            next_st.stop_mode = 1'b0;
        end else if (stop_exec && !stop_dis && st.opt_valid) begin
            next_st.stop_mode = 1'b1;
        end
        // pending request: set wins over clear
        if (irq_set) begin
            next_st.pend = 1'b1;
        end else if (irq_clr) begin
            next_st.pend = 1'b0;
        end
        next_st.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                pcei_pkg::OFF_PA_DATA: next_st.rdata = 8'(pa_rd);
                pcei_pkg::OFF_PB_DATA: next_st.rdata = pb_rd;
                pcei_pkg::OFF_PC_DATA: next_st.rdata = pc_rd;
                pcei_pkg::OFF_PD_DATA: next_st.rdata = 8'(pd_rd);
                pcei_pkg::OFF_PA_DIR: next_st.rdata = 8'(st.pa_dir);
                pcei_pkg::OFF_PB_DIR: next_st.rdata = st.pb_dir;
                pcei_pkg::OFF_PC_DIR: next_st.rdata = st.pc_dir;
                pcei_pkg::OFF_AD_CTRL: begin
                    next_st.rdata[pcei_pkg::AD_ON_BIT] = st.ad_on;
                    next_st.rdata[pcei_pkg::AD_CH_LSB +: pcei_pkg::AD_CH_W] = st.ad_chan;
                end
                pcei_pkg::OFF_IRQ_CTRL: begin
                    next_st.rdata[pcei_pkg::IRQ_EN_BIT] = st.irq_en;
                    next_st.rdata[pcei_pkg::IRQ_PEND_BIT] = st.pend;
                    next_st.rdata[pcei_pkg::IRQ_PIN_BIT] = st.irq_s[1];
                end
                pcei_pkg::OFF_OPTION: next_st.rdata = 8'(st.opt);
                pcei_pkg::OFF_MODE: next_st.rdata = {7'h00, st.boot_mode};
                default: next_st.rdata = '0;
            endcase
        end
        if (bus.wr) begin
            case (bus.addr)
                pcei_pkg::OFF_PA_DATA: next_st.pa_d = bus.wdata[pcei_pkg::PA_W-1:0];
                pcei_pkg::OFF_PB_DATA: next_st.pb_d = bus.wdata;
                pcei_pkg::OFF_PC_DATA: next_st.pc_d = bus.wdata;
                pcei_pkg::OFF_PA_DIR: next_st.pa_dir = bus.wdata[pcei_pkg::PA_W-1:0];
                pcei_pkg::OFF_PB_DIR: next_st.pb_dir = bus.wdata;
                pcei_pkg::OFF_PC_DIR: next_st.pc_dir = bus.wdata;
                pcei_pkg::OFF_AD_CTRL: begin
                    next_st.ad_on = bus.wdata[pcei_pkg::AD_ON_BIT];
                    next_st.ad_chan = bus.wdata[pcei_pkg::AD_CH_LSB +: pcei_pkg::AD_CH_W];
                end
                pcei_pkg::OFF_IRQ_CTRL: next_st.irq_en = bus.wdata[pcei_pkg::IRQ_EN_BIT];
                default: begin
                end
            endcase
        end
        // processor reset returns software state to defaults
        if (cpu_reset) begin
            next_st.pa_d = pcei_pkg::DATA_RST[pcei_pkg::PA_W-1:0];
            next_st.pb_d = pcei_pkg::DATA_RST;
            next_st.pc_d = pcei_pkg::DATA_RST;
            next_st.pa_dir = pcei_pkg::DIR_RST[pcei_pkg::PA_W-1:0];
            next_st.pb_dir = pcei_pkg::DIR_RST;
            next_st.pc_dir = pcei_pkg::DIR_RST;
            next_st.ad_on = 1'b0;
            next_st.ad_chan = '0;
            next_st.irq_en = 1'b0;
            next_st.pend = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.rst_cnt <= pcei_pkg::RST_HOLD;
            st.rst_s <= 2'h3;
            st.irq_s <= 2'h3;
            st.irq_prev <= 1'b1;
            st.pc_s0 <= 8'hff;
            st.pc_s1 <= 8'hff;
            st.pc_prev <= 8'hff;
        end else begin
            st <= next_st;
        end
    end

    // hysteresis lives in the pad; here the pin is synchronised
    assign cpu_reset = (st.rst_cnt != '0) | ~st.rst_s[1];
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = (st.rst_cnt != '0);
    assign rdata = st.rdata;
    assign boot_mode = st.boot_mode;
    assign watchdog_system_en = st.opt[pcei_pkg::OPT_WDOG_EN];
    assign stop_mode = st.stop_mode;
    // the inverter path stays combinational, as in the pad
    assign oscillator_output_pin = st.stop_mode | ~oscillator_input_pin;
    assign op_clock_out = st.div;
    assign irq_req = wake & ~cpu_irq_mask;
    assign first_port_lines_out = st.pa_d;
    assign first_port_lines_oe = st.pa_dir;
    assign second_port_out = (pb_own & pb_per_out) | (~pb_own & st.pb_d);
    assign second_port_oe = (pb_own & pb_per_oe) | (~pb_own & st.pb_dir);
    assign second_port_serial_lines_in = st.pb_s1[3:0];
    assign second_port_capture_in = st.pb_s1[7];
    assign third_port_wakeup_lines_out = st.pc_d;
    assign third_port_wakeup_lines_oe = st.pc_dir;
    assign ad_enable = st.ad_on;
    assign ad_channel = st.ad_chan;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    level_irq_a: assert property (lvl_on && st.irq_en && !st.irq_s[1]
        && !cpu_irq_mask |-> irq_req)
        else $error("level low not requesting");
    edge_only_a: assert property (!lvl_on && !st.pend |-> !irq_req)
        else $error("request without pending edge");
    pc_edge_a: assert property ((st.irq_en && |pc_fall && !cpu_reset) |=> st.pend)
        else $error("third port edge lost");
    pc_gate_a: assert property ((!st.irq_en && !st.pend && !irq_fall) |=> !st.pend)
        else $error("pending while disabled");
    lvr_hold_a: assert property ((st.opt[pcei_pkg::OPT_LVR_EN] && low_supply_detect)
        |=> cpu_reset && reset_pin_oe)
        else $error("low supply not held in reset");
    stop_reset_a: assert property ((stop_exec && stop_dis) |=> reset_pin_oe && !st.stop_mode)
        else $error("disabled stop did not reset");
    osc_stop_a: assert property ((stop_exec && !stop_dis && st.opt_valid && !cpu_reset && !wake)
        |=> oscillator_output_pin)
        else $error("oscillator output not high in stop");
    div_half_a: assert property (osc_rise |=> op_clock_out != $past(op_clock_out))
        else $error("divider missed source edge");
    pin_stretch_a: assert property (int_rst |=> reset_pin_oe [*8])
        else $error("reset pin pulse too short");
    irq_mask_a: assert property (cpu_irq_mask |-> !irq_req)
        else $error("masked request visible");
    dir_reset_a: assert property (cpu_reset |=> st.pa_dir == '0 && st.pb_dir == '0
        && st.pc_dir == '0 && !st.ad_on)
        else $error("ports not inputs after reset");
    ad_zero_a: assert property ((bus.rd && bus.addr == pcei_pkg::OFF_PD_DATA && st.ad_on
        && st.ad_chan < 3'(pcei_pkg::PD_W)) |=> rdata[$past(st.ad_chan)] == 1'b0)
        else $error("selected analog pin read nonzero");
    pend_hold_a: assert property ((st.pend && !irq_clr && !cpu_reset) |=> st.pend)
        else $error("pending dropped without acknowledge");

    stop_wake_c: cover property (st.stop_mode ##[1:20] !st.stop_mode);
    pc_irq_c: cover property (st.irq_en && |pc_fall ##1 irq_req);
    lvl_irq_c: cover property (level_req && !cpu_irq_mask);
    ad_read_c: cover property (bus.rd && bus.addr == pcei_pkg::OFF_PD_DATA && st.ad_on);
endmodule
`default_nettype wire

// ---- test/pcei_board.sv ----
// board-side model: pulled-up reset, interrupt and port c lines, free-running clock source
`timescale 1ns/1ps
`default_nettype none
module pcei_board #(
    parameter int OSC_HALF = 200
) (
    input wire logic rst_oe,
    input wire logic ext_rst,
    input wire logic irq_low,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe,
    input wire logic [7:0] pc_low,
    output logic rst_pin,
    output logic irq_pin,
    output logic osc,
    output logic [7:0] pc_pin
);
    // open-drain reset line: low while the device or the switch pulls it
    assign rst_pin = ~(rst_oe | ext_rst);
    assign irq_pin = ~irq_low;
    // released lines fall back to their pull-ups
    assign pc_pin = (pc_oe & pc_out) | (~pc_oe & ~pc_low);
    initial begin
        osc = 1'b0;
        #7;
        forever #(OSC_HALF) osc = ~osc;
    end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the pin control and external interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
    localparam int OSC_HALF = 200;
    localparam logic [7:0] IEN = 8'h01 << pcei_pkg::IRQ_EN_BIT;
    localparam logic [7:0] IACK = 8'h01 << pcei_pkg::IRQ_ACK_BIT;
    localparam logic [7:0] IPND = 8'h01 << pcei_pkg::IRQ_PEND_BIT;
    logic clk, resetn, boot, boot_mode, wd_en, stop_mode, cpu_reset, rst_pin, rst_oe, osc;
    logic osc_out, op_clk, irq_pin, mask, ack, irq_req, ext_rst, irq_low, ser_en, pwa_en, pwa;
    logic pwb_en, pwb, cmp_en, cmp, cap_en, cap_in, ad_en, rst_out;
    logic [3:0] opts, src, ser_out, ser_oe, ser_in;
    logic [7:0] rdata, pb_in, pb_drv, pb_out, pb_oe, pc_pin, pc_out, pc_oe, pc_low;
    logic [6:0] pa_in, pa_out, pa_oe;
    logic [4:0] an;
    logic [2:0] ad_ch;
    pcei_pkg::pcei_bus_t bus;
    int num_errors = 0;
    int n_checks = 0;
    real t0;

    // two-way port lines: device drives where enabled, board elsewhere
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & 7'h55);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_drv);

    pcei_board #(.OSC_HALF(OSC_HALF)) pcei_board_i (
        .rst_oe(rst_oe), .ext_rst(ext_rst), .irq_low(irq_low), .pc_out(pc_out),
        .pc_oe(pc_oe), .pc_low(pc_low), .rst_pin(rst_pin), .irq_pin(irq_pin), .osc(osc),
        .pc_pin(pc_pin)
    );
    pcei_pin_ctrl pcei_pin_ctrl_i (
        .clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .option_config_register(opts),
        .boot_strap(boot), .boot_mode(boot_mode), .watchdog_system_en(wd_en),
        .watchdog_timeout(src[0]), .low_supply_detect(src[1]), .illegal_addr(src[2]),
        .stop_exec(src[3]), .stop_mode(stop_mode), .cpu_reset(cpu_reset),
        .reset_pin_in(rst_pin), .reset_pin_out(rst_out), .reset_pin_oe(rst_oe),
        .oscillator_input_pin(osc), .oscillator_output_pin(osc_out), .op_clock_out(op_clk),
        .irq_pin_in(irq_pin), .cpu_irq_mask(mask), .cpu_irq_ack(ack), .irq_req(irq_req),
        .first_port_lines_in(pa_in), .first_port_lines_out(pa_out), .first_port_lines_oe(pa_oe),
        .second_port_in(pb_in), .second_port_out(pb_out), .second_port_oe(pb_oe),
        .second_port_serial_en(ser_en), .second_port_serial_lines_out(ser_out),
        .second_port_serial_lines_oe(ser_oe), .second_port_serial_lines_in(ser_in),
        .pwm_a_en(pwa_en), .second_port_pwm_out_a(pwa), .pwm_b_en(pwb_en),
        .second_port_pwm_out_b(pwb), .compare_en(cmp_en), .second_port_compare_out(cmp),
        .capture_en(cap_en), .second_port_capture_in(cap_in),
        .third_port_wakeup_lines_in(pc_pin), .third_port_wakeup_lines_out(pc_out),
        .third_port_wakeup_lines_oe(pc_oe), .analog_shared_inputs(an), .ad_enable(ad_en),
        .ad_channel(ad_ch)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask
    task automatic chk_rd(string nm, logic [7:0] a, logic [7:0] m, logic [7:0] e);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        `CHK(nm, e, rdata & m)
    endtask
    task automatic pulse(logic [3:0] s);
        @(posedge clk);
        src <= s;
        @(posedge clk);
        src <= 4'h0;
        #1;
    endtask
    task automatic ackp();
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        #1;
    endtask
    task automatic wait_rel();
        for (int i = 0; i < 100 && cpu_reset !== 1'b0; i++) @(posedge clk);
        #1;
        `CHK("cpu reset released", 1'b0, cpu_reset)
    endtask
    task automatic done(string nm);
        $display("test %s finished, %0d mismatches so far", nm, num_errors);
    endtask
    task automatic do_reset(logic [3:0] o, logic b);
        @(posedge clk);
        resetn <= 1'b0;
        opts <= o;
        boot <= b;
        tick(6);
        `CHK("power-on pull", 1'b1, rst_oe)
        `CHK("pull level", 1'b0, rst_out)
        @(posedge clk);
        resetn <= 1'b1;
        wait_rel();
    endtask

    task automatic t_power();
        `CHK("all oe", 23'h0, {pa_oe, pb_oe, pc_oe})
        `CHK("watchdog enable", opts[pcei_pkg::OPT_WDOG_EN], wd_en)
        `CHK("boot mode", boot, boot_mode)
        chk_rd("options", pcei_pkg::OFF_OPTION, 8'h0f, {4'h0, opts});
        chk_rd("mode", pcei_pkg::OFF_MODE, 8'h01, {7'h0, boot});
        chk_rd("ad ctrl", pcei_pkg::OFF_AD_CTRL, 8'hff, 8'h00);
        chk_rd("unmapped", 8'h3f, 8'hff, 8'h00);
        done("power");
    endtask
    task automatic t_osc();
        `CHK("osc out", ~osc, osc_out)
        @(posedge op_clk);
        t0 = $realtime;
        @(posedge op_clk);
        `CHK("op clock period", 4 * OSC_HALF, int'($realtime - t0))
        done("osc");
    endtask
    task automatic t_ports();
        chk_rd("port a in", pcei_pkg::OFF_PA_DATA, 8'h7f, 8'h55);
        wr(pcei_pkg::OFF_PA_DIR, 8'h7f);
        wr(pcei_pkg::OFF_PA_DATA, 8'h2a);
        `CHK("port a oe", 7'h7f, pa_oe)
        `CHK("port a out", 7'h2a, pa_out)
        @(posedge clk);
        {ser_en, pwa_en, pwa, pwb_en, pwb, cmp_en, cmp, cap_en} <= 8'b1110_1111;
        ser_out <= 4'ha;
        ser_oe <= 4'h3;
        pb_drv <= 8'h84;
        wr(pcei_pkg::OFF_PB_DIR, 8'hff);
        tick(4);
        `CHK("port b oe", 8'h73, pb_oe)
        `CHK("port b out", 8'h52, pb_out & pb_oe)
        `CHK("serial in", 4'h6, ser_in)
        `CHK("capture in", 1'b1, cap_in)
        wr(pcei_pkg::OFF_PC_DIR, 8'hff);
        wr(pcei_pkg::OFF_PC_DATA, 8'h3c);
        `CHK("port c pins", 8'h3c, pc_pin)
        wr(pcei_pkg::OFF_PC_DIR, 8'h00);
        // released pins need the synchroniser before they read back
        tick(2);
        chk_rd("port c in", pcei_pkg::OFF_PC_DATA, 8'hff, 8'hff);
        chk_rd("port d off", pcei_pkg::OFF_PD_DATA, 8'h1f, 8'h16);
        for (int c = 0; c < 5; c++) begin
            wr(pcei_pkg::OFF_AD_CTRL, (8'h01 << pcei_pkg::AD_ON_BIT) | 8'(c));
            `CHK("ad on", 1'b1, ad_en)
            `CHK("ad channel", 3'(c), ad_ch)
            chk_rd("port d on", pcei_pkg::OFF_PD_DATA, 8'h1f, 8'h16 & ~(8'h01 << c));
        end
        wr(pcei_pkg::OFF_AD_CTRL, 8'h00);
        @(posedge clk);
        {ser_en, pwa_en, pwb_en, cmp_en, cap_en} <= 5'h00;
        done("ports");
    endtask
    task automatic t_irq();
        pulse(4'h1);
        `CHK("watchdog off", 1'b0, rst_oe)
        pulse(4'h2);
        `CHK("low supply off", 1'b0, rst_oe)
        wr(pcei_pkg::OFF_IRQ_CTRL, IEN);
        pulse(4'h8);
        `CHK("stop entered", 1'b1, stop_mode)
        `CHK("osc out in stop", 1'b1, osc_out)
        @(posedge clk);
        irq_low <= 1'b1;
        tick(5);
        `CHK("irq request", 1'b1, irq_req)
        `CHK("stop woken", 1'b0, stop_mode)
        chk_rd("irq status", pcei_pkg::OFF_IRQ_CTRL, IEN | IPND | 8'h01, IEN | IPND);
        @(posedge clk);
        mask <= 1'b1;
        tick(2);
        `CHK("masked request", 1'b0, irq_req)
        @(posedge clk);
        mask <= 1'b0;
        ackp();
        tick(2);
        `CHK("edge only after ack", 1'b0, irq_req)
        irq_low <= 1'b0;
        pc_low <= 8'h20;
        tick(5);
        `CHK("port c request", 1'b1, irq_req)
        wr(pcei_pkg::OFF_IRQ_CTRL, IEN | IACK);
        tick(1);
        `CHK("ack by write", 1'b0, irq_req)
        pc_low <= 8'h00;
        wr(pcei_pkg::OFF_IRQ_CTRL, 8'h00);
        pc_low <= 8'h01;
        tick(5);
        chk_rd("gated port c", pcei_pkg::OFF_IRQ_CTRL, IPND, 8'h00);
        pc_low <= 8'h00;
        done("irq edge");
    endtask
    task automatic t_level();
        wr(pcei_pkg::OFF_IRQ_CTRL, IEN);
        irq_low <= 1'b1;
        tick(5);
        ackp();
        tick(2);
        `CHK("level request", 1'b1, irq_req)
        irq_low <= 1'b0;
        tick(4);
        `CHK("level released", 1'b0, irq_req)
        pc_low <= 8'h80;
        tick(5);
        `CHK("port c edge", 1'b1, irq_req)
        ackp();
        tick(2);
        `CHK("port c not level", 1'b0, irq_req)
        pc_low <= 8'h00;
        done("irq level");
    endtask
    task automatic t_int_rst();
        for (int i = 0; i < 4; i++) begin
            pulse(4'h1 << i);
            `CHK("reset pin pull", 1'b1, rst_oe)
            tick(3);
            `CHK("cpu in reset", 1'b1, cpu_reset)
            `CHK("stop refused", 1'b0, stop_mode)
            wait_rel();
        end
        @(posedge clk);
        src <= 4'h2;
        tick(60);
        `CHK("low supply hold", 1'b1, cpu_reset)
        @(posedge clk);
        src <= 4'h0;
        wait_rel();
        wr(pcei_pkg::OFF_PA_DIR, 8'h7f);
        ext_rst <= 1'b1;
        tick(4);
        `CHK("external reset", 1'b1, cpu_reset)
        ext_rst <= 1'b0;
        wait_rel();
        `CHK("port a back to input", 7'h00, pa_oe)
        chk_rd("port a dir", pcei_pkg::OFF_PA_DIR, 8'h7f, 8'h00);
        done("internal resets");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        num_errors++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        resetn = 1'b0;
        bus = '0;
        opts = 4'h0;
        src = 4'h0;
        boot = 1'b0;
        {mask, ack, ext_rst, irq_low, ser_en, pwa_en, pwa, pwb_en, pwb, cmp_en, cmp, cap_en} = '0;
        {ser_out, ser_oe, pb_drv, pc_low} = '0;
        an = 5'h16;
        do_reset(4'h0, 1'b0);
        t_power();
        t_osc();
        t_ports();
        t_irq();
        do_reset(4'hf, 1'b1);
        t_power();
        t_level();
        t_int_rst();
        finish_test();
    end
endmodule
`default_nettype wire
